// [core/ssd_digitizer.sv]
// Star and sun sensor digitizer with its record FIFO
`timescale 1ns/1ps

module ssd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW:0] fill = wr_ptr - rd_ptr;
   // Honest full and empty from pointer distance
   assign in_ready = (fill != (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data = mem[rd_ptr[AW-1:0]];
   // Storage has no reset; only pointers are control state
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(push);
         rd_ptr <= rd_ptr + (AW+1)'(pop);
      end
   end

   // Fill never passes the depth; a wrap here would corrupt stored records
   AST_FIFO_CAP: assert property (@(posedge mclk) disable iff (!rstn)
      fill <= (AW+1)'(DEPTH)) else $error("fifo fill beyond depth");
endmodule

module ssd_digitizer #(
   parameter int TIME_W = ssd_pkg::TIME_W,
   parameter int DEPTH = ssd_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Timing unit
   input wire logic [TIME_W-1:0] sys_time,
   input wire logic time_tick,
   input wire logic rev_start,
   // Sensors and windows
   input wire logic star_pulse,
   input wire logic sun_slit0,
   input wire logic sun_slit1,
   input wire logic sun_select,
   input wire logic space_window,
   // Threshold step to the variable threshold unit
   output logic [ssd_pkg::STEP_W-1:0] thresh_step,
   // Record stream to storage
   output logic rec_valid,
   input wire logic rec_ready,
   output ssd_pkg::ssd_rec_t rec_data,
   output logic rec_dropped
);
   // Synchroniser stages: first stage read only by the second
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic [6:0] prev;
   wire [6:0] raw = {rev_start, time_tick, space_window, sun_select, sun_slit1, sun_slit0,
                     star_pulse};
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         prev <= sync2;
      end
   end
   wire [6:0] rise = sync2 & ~prev;
   wire [6:0] fall = ~sync2 & prev;
   wire s_window = sync2[4];
   wire s_sun = sync2[3];
   wire tick = rise[5];
   wire rev = rise[6];

   // Revolution star and pulse bookkeeping
   logic [4:0] pulse_cnt;
   logic [1:0] slit_idx;
   logic [3:0] star_cnt;
   logic [ssd_pkg::STEP_W-1:0] step;
   logic star_active;
   logic [TIME_W-1:0] star_time;
   logic [ssd_pkg::STAR_TRANSIT_W-1:0] star_width;
   logic star_keep;
   wire star_ok = !s_sun && s_window;
   wire star_lead = rise[0] && star_ok;
   wire star_trail = fall[0] && star_active;
   // Every seen pulse feeds the threshold; only the first eighteen are stored,
   // otherwise a crowded sky could never push the threshold up
   wire star_emit = star_trail && star_keep;
   // Star count saturates so a very dense revolution cannot wrap to a low count
   wire star_done = (slit_idx == 2'h2) && star_trail && (star_cnt != 4'hf);
   wire [3:0] total_stars = star_cnt + 4'(star_done);
   wire step_up = (total_stars > ssd_pkg::STAR_TARGET) && (step != ssd_pkg::STEP_MAX);
   wire step_dn = (total_stars < ssd_pkg::STAR_TARGET) && (step != ssd_pkg::STEP_MIN);
   assign thresh_step = step;

   // Star capture: lead latches time, ticks count width, trail emits
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         star_active <= 1'b0;
         star_keep <= 1'b0;
         star_time <= '0;
         star_width <= '0;
      end else if (star_lead) begin
         star_active <= 1'b1;
         // Store decision is taken at the lead so a pulse is kept whole or not at all
         star_keep <= (pulse_cnt < ssd_pkg::PULSE_LIMIT);
         star_time <= sys_time;
         star_width <= '0;
      end else if (star_trail) begin
         star_active <= 1'b0;
      end else if (star_active && tick && (star_width != '1)) begin
         star_width <= star_width + 1'b1;
      end
   end

   // Revolution counters and threshold stepping
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pulse_cnt <= '0;
         slit_idx <= '0;
         star_cnt <= '0;
         step <= ssd_pkg::STEP_RESET;
      end else if (rev) begin
         pulse_cnt <= '0;
         slit_idx <= '0;
         star_cnt <= '0;
         if (step_up) begin
            step <= step + 1'b1;
         end else if (step_dn) begin
            step <= step - 1'b1;
         end
      end else if (star_trail) begin
         pulse_cnt <= pulse_cnt + 5'(star_keep);
         // Three slit pulses make one star
         slit_idx <= (slit_idx == 2'h2) ? 2'h0 : slit_idx + 1'b1;
         star_cnt <= total_stars;
      end
   end

   // Sun sensor: both slits, on and off edges, 10-bit transit
   logic [1:0] sun_on;
   logic [ssd_pkg::SUN_TRANSIT_W-1:0] sun_width [2];
   logic label_due;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sun
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               sun_on[g] <= 1'b0;
               sun_width[g] <= '0;
            end else if (rise[1+g] && s_sun) begin
               sun_on[g] <= 1'b1;
               sun_width[g] <= '0;
            end else if (fall[1+g]) begin
               sun_on[g] <= 1'b0;
            end else if (sun_on[g] && tick && (sun_width[g] != '1)) begin
               sun_width[g] <= sun_width[g] + 1'b1;
            end
         end
      end
   endgenerate

   // Record select; one event per cycle, star first, label last
   wire sun_on_ev0 = rise[1] && s_sun;
   wire sun_on_ev1 = rise[2] && s_sun;
   wire sun_off_ev0 = fall[1] && sun_on[0];
   wire sun_off_ev1 = fall[2] && sun_on[1];
   ssd_pkg::ssd_rec_t next_rec;
   logic next_push;
   always_comb begin
      next_rec = '0;
      next_push = 1'b0;
      next_rec.mag = step;
      next_rec.stamp = sys_time;
      if (star_emit) begin
         next_push = 1'b1;
         next_rec.kind = ssd_pkg::SSD_KIND_STAR;
         next_rec.stamp = star_time;
         next_rec.width = ssd_pkg::SUN_TRANSIT_W'(star_width);
      end else if (sun_on_ev0 || sun_on_ev1) begin
         next_push = 1'b1;
         next_rec.kind = ssd_pkg::SSD_KIND_SUN_ON;
         next_rec.slit = sun_on_ev1 && !sun_on_ev0;
      end else if (sun_off_ev0 || sun_off_ev1) begin
         next_push = 1'b1;
         next_rec.kind = ssd_pkg::SSD_KIND_SUN_OFF;
         next_rec.slit = sun_off_ev1 && !sun_off_ev0;
         next_rec.width = next_rec.slit ? sun_width[1] : sun_width[0];
      end else if (label_due) begin
         next_push = 1'b1;
         next_rec.kind = ssd_pkg::SSD_KIND_LABEL;
      end
   end

   // Label waits for a free cycle; rare coincident sun edges keep the lower slit
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         label_due <= 1'b0;
      end else if (rev && s_sun) begin
         label_due <= 1'b1;
      end else if (next_push && (next_rec.kind == ssd_pkg::SSD_KIND_LABEL)) begin
         label_due <= 1'b0;
      end
   end

   // Register record into FIFO; full FIFO drops and flags
   logic push_q;
   ssd_pkg::ssd_rec_t rec_q;
   logic fifo_ready;
   logic out_v;
   ssd_pkg::ssd_rec_t out_d;
   // Pop only when the output slice loads, else a stalled slice loses a word
   wire take = out_v && (!rec_valid || rec_ready);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         push_q <= 1'b0;
         rec_q <= '0;
         rec_dropped <= 1'b0;
      end else begin
         push_q <= next_push;
         rec_q <= next_rec;
         rec_dropped <= push_q && !fifo_ready;
      end
   end
   ssd_fifo #(.WIDTH(ssd_pkg::REC_W), .DEPTH(DEPTH)) u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(push_q),
      .in_ready(fifo_ready),
      .in_data(rec_q),
      .out_valid(out_v),
      .out_ready(take),
      .out_data(out_d)
   );
   // Output stage is a skid-free register slice
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rec_valid <= 1'b0;
         rec_data <= '0;
      end else if (!rec_valid || rec_ready) begin
         rec_valid <= out_v;
         rec_data <= out_d;
      end
   end

   // Checks
   AST_STEP_UP: assert property (@(posedge mclk) disable iff (!rstn)
      rev && step_up |=> step == $past(step) + 1'b1) else $error("step not raised");
   AST_STEP_DN: assert property (@(posedge mclk) disable iff (!rstn)
      rev && step_dn |=> step == $past(step) - 1'b1) else $error("step not lowered");
   AST_STEP_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
      !rev |=> $stable(step)) else $error("step moved mid revolution");
   AST_LEAD_TIME: assert property (@(posedge mclk) disable iff (!rstn)
      star_lead |=> star_time == $past(sys_time)) else $error("time not captured");
   AST_WIDTH: assert property (@(posedge mclk) disable iff (!rstn)
      star_active && !star_lead && !star_trail && !tick |=> $stable(star_width))
      else $error("width moved without tick");
   AST_EMIT: assert property (@(posedge mclk) disable iff (!rstn)
      star_emit |=> push_q && rec_q.kind == ssd_pkg::SSD_KIND_STAR)
      else $error("star record not emitted");
   AST_LIMIT: assert property (@(posedge mclk) disable iff (!rstn)
      pulse_cnt <= ssd_pkg::PULSE_LIMIT) else $error("too many star pulses");
   // Store decision follows the count of pulses already stored
   AST_KEEP: assert property (@(posedge mclk) disable iff (!rstn)
      star_lead |=> star_keep == ($past(pulse_cnt) < ssd_pkg::PULSE_LIMIT))
      else $error("store decision wrong");
   AST_WINDOW: assert property (@(posedge mclk) disable iff (!rstn)
      star_lead |-> s_window && !s_sun) else $error("star outside window");
   AST_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
      rev |=> star_cnt == 4'h0 && pulse_cnt == 5'h00) else $error("counter not cleared");
   // Sun records carry the live time on entry and the ten-bit width on exit
   AST_SUN_ON: assert property (@(posedge mclk) disable iff (!rstn)
      sun_on_ev0 && !star_emit |=> push_q && rec_q.kind == ssd_pkg::SSD_KIND_SUN_ON
      && rec_q.stamp == $past(sys_time)) else $error("sun on record wrong");
   AST_SUN_OFF: assert property (@(posedge mclk) disable iff (!rstn)
      sun_off_ev0 && !star_emit && !sun_on_ev0 && !sun_on_ev1 |=> push_q
      && rec_q.kind == ssd_pkg::SSD_KIND_SUN_OFF && rec_q.width == $past(sun_width[0]))
      else $error("sun off record wrong");
   // Label request set wins over a label leaving in the same cycle
   AST_LABEL: assert property (@(posedge mclk) disable iff (!rstn)
      rev && s_sun |=> label_due) else $error("label not pending");
   AST_MAG: assert property (@(posedge mclk) disable iff (!rstn)
      push_q |-> rec_q.mag == $past(step)) else $error("magnitude not step");
endmodule

// [core/ssd_pkg.sv]
// Package for the star and sun sensor digitizer: constants and carrier types
package ssd_pkg;
   localparam int TIME_W = 16;
   localparam int STAR_TRANSIT_W = 8;
   localparam int SUN_TRANSIT_W = 10;
   localparam int STEP_W = 4;
   localparam logic [STEP_W-1:0] STEP_MAX = 4'hf;
   localparam logic [STEP_W-1:0] STEP_MIN = 4'h0;
   localparam logic [STEP_W-1:0] STEP_RESET = 4'h8;
   localparam logic [3:0] STAR_TARGET = 4'h6;
   localparam logic [1:0] SLITS_STAR = 2'h3;
   localparam logic [4:0] PULSE_LIMIT = 5'h12;
   localparam real TICK_US = 26.7;
   localparam real CLK_NS = 5.0;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [1:0] {
      SSD_KIND_STAR = 2'h0,
      SSD_KIND_SUN_ON = 2'h1,
      SSD_KIND_SUN_OFF = 2'h2,
      SSD_KIND_LABEL = 2'h3
   } ssd_kind_t;
   typedef struct packed {
      ssd_kind_t kind;
      logic [0:0] slit;
      logic [TIME_W-1:0] stamp;
      logic [SUN_TRANSIT_W-1:0] width;
      logic [STEP_W-1:0] mag;
   } ssd_rec_t;
   localparam int REC_W = $bits(ssd_rec_t);
endpackage

// [testbench/ssd_digitizer_tb.sv]
// Self-checking bench for the star and sun sensor digitizer
`timescale 1ns/1ps
`define P i_ssd_partner
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module ssd_digitizer_tb;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [ssd_pkg::TIME_W-1:0] sys_time;
   logic time_tick, rev_start, star_pulse, sun_slit0, sun_slit1;
   logic sun_select, space_window, rec_valid, rec_ready, rec_dropped;
   logic [ssd_pkg::STEP_W-1:0] thresh_step;
   ssd_pkg::ssd_rec_t rec_data;
   int err_count = 0;
   int n_checks = 0;
   always #2.5 mclk = ~mclk;
   ssd_digitizer i_ssd_digitizer (.mclk(mclk), .rstn(rstn), .sys_time(sys_time),
      .time_tick(time_tick), .rev_start(rev_start), .star_pulse(star_pulse),
      .sun_slit0(sun_slit0), .sun_slit1(sun_slit1), .sun_select(sun_select),
      .space_window(space_window), .thresh_step(thresh_step), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec_data(rec_data), .rec_dropped(rec_dropped));
   ssd_partner i_ssd_partner (.mclk(mclk), .sys_time(sys_time), .time_tick(time_tick),
      .rev_start(rev_start), .star_pulse(star_pulse), .sun_slit0(sun_slit0),
      .sun_slit1(sun_slit1), .sun_select(sun_select), .space_window(space_window),
      .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data),
      .rec_dropped(rec_dropped));
   // Next stored word; mask m picks slit, stamp, width, mag
   task automatic take(input logic [3:0] m, input ssd_pkg::ssd_kind_t k, input logic s,
      input logic [15:0] t, input logic [9:0] w, input logic [3:0] g);
      ssd_pkg::ssd_rec_t r;
      for (int n = 0; n < 400 && `P.got.size() == 0; n++) @(posedge mclk);
      r = '1;
      if (`P.got.size() != 0) r = `P.got.pop_front();
      `CHK("kind", k, r.kind)
      if (m[0]) `CHK("slit", s, r.slit)
      if (m[1]) `CHK("stamp", t, r.stamp)
      if (m[2]) `CHK("width", w, r.width)
      if (m[3]) `CHK("mag", g, r.mag)
   endtask
   task automatic stars(input int n);
      logic [15:0] t;
      repeat (3 * n) `P.pulse(0, 1, t);
   endtask
   // One star, three slits of growing width
   task automatic t_star();
      logic [15:0] t;
      `P.mode(1'b0, 1'b1);
      for (int w = 2; w < 5; w++) begin
         `P.pulse(0, w, t);
         take(4'he, ssd_pkg::SSD_KIND_STAR, 1'b0, t, 10'(w), 4'h8);
      end
      $display("star capture test done");
   endtask
   // Star outside the window or while sun selected; sun while star selected
   task automatic t_refuse();
      logic [15:0] t;
      `P.mode(1'b0, 1'b0);
      `P.pulse(0, 1, t);
      `P.mode(1'b1, 1'b1);
      `P.pulse(0, 1, t);
      `P.mode(1'b0, 1'b1);
      `P.pulse(1, 1, t);
      repeat (20) @(posedge mclk);
      `CHK("refused", 0, `P.got.size())
      $display("refusal test done");
   endtask
   // Threshold steps, per-revolution cap and FIFO overflow under stall
   task automatic t_thresh();
      `P.rev();
      `CHK("step down", 4'h7, thresh_step)
      `P.stall = 1'b1;
      stars(7);
      `P.rev();
      `CHK("step up", 4'h8, thresh_step)
      stars(7);
      @(posedge mclk);
      #1 `P.stall = 1'b0;
      repeat (80) @(posedge mclk);
      `CHK("kept", 36, `P.got.size() + `P.drops)
      `CHK("dropped", 1'b1, `P.drops > 0)
      `CHK("mag", 4'h7, `P.got[0].mag)
      `CHK("drained", 1'b0, rec_valid)
      `P.got.delete();
      `P.rev();
      stars(6);
      `P.rev();
      `CHK("step hold", 4'h9, thresh_step)
      repeat (7) begin
         stars(7);
         `P.rev();
      end
      `CHK("step top", 4'hf, thresh_step)
      repeat (16) `P.rev();
      `CHK("step bottom", 4'h0, thresh_step)
      `P.got.delete();
      $display("threshold test done");
   endtask
   // Label, then on and off times of both slits; long slit exceeds 8 bits
   task automatic t_sun();
      logic [15:0] t;
      `P.mode(1'b1, 1'b0);
      `P.rev();
      take(4'h0, ssd_pkg::SSD_KIND_LABEL, 1'b0, 16'h0, 10'h0, 4'h0);
      `P.pulse(1, 300, t);
      take(4'h3, ssd_pkg::SSD_KIND_SUN_ON, 1'b0, t, 10'h0, 4'h0);
      take(4'h7, ssd_pkg::SSD_KIND_SUN_OFF, 1'b0, t + 16'h12c, 10'h12c, 4'h0);
      `P.pulse(2, 5, t);
      take(4'h3, ssd_pkg::SSD_KIND_SUN_ON, 1'b1, t, 10'h0, 4'h0);
      take(4'h7, ssd_pkg::SSD_KIND_SUN_OFF, 1'b1, t + 16'h5, 10'h5, 4'h0);
      $display("sun sensor test done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      #1 rstn = 1'b1;
      `CHK("reset step", 4'h8, thresh_step)
      `CHK("reset valid", 1'b0, rec_valid)
      t_star();
      t_refuse();
      t_thresh();
      t_sun();
      summarize();
   end
   // Whole run needs some 7k cycles
   initial begin
      #400000;
      err_count++;
      $display("[FAIL] watchdog expected end seen hang");
      summarize();
   end
endmodule

// [testbench/ssd_partner.sv]
// Sensors, timing unit and storage model facing the digitizer
`timescale 1ns/1ps
module ssd_partner (
   // Clock
   input wire logic mclk,
   // Timing unit
   output logic [ssd_pkg::TIME_W-1:0] sys_time,
   output logic time_tick,
   output logic rev_start,
   // Sensors and windows
   output logic star_pulse,
   output logic sun_slit0,
   output logic sun_slit1,
   output logic sun_select,
   output logic space_window,
   // Storage
   input wire logic rec_valid,
   output logic rec_ready,
   input wire ssd_pkg::ssd_rec_t rec_data,
   input wire logic rec_dropped
);
   logic [2:0] ph = 3'h0;
   logic stall = 1'b0;
   int drops = 0;
   ssd_pkg::ssd_rec_t got[$];
   initial begin
      {sys_time, rev_start, star_pulse, sun_slit0, sun_slit1} = '0;
      {sun_select, space_window} = 2'h0;
   end
   // Tick every 8 cycles; time word steps with it
   always @(posedge mclk) begin
      ph <= #1 ph + 3'h1;
      if (ph == 3'h7) begin
         sys_time <= #1 sys_time + 1'h1;
      end
   end
   assign time_tick = ph < 3'h4;
   assign rec_ready = ~stall;
   // Storage keeps accepted words; a stall lets the FIFO fill
   always @(posedge mclk) begin
      if (rec_valid === 1'b1 && rec_ready) begin
         got.push_back(rec_data);
      end
      if (rec_dropped === 1'b1) begin
         drops++;
      end
   end
   // Programming unit picks sensor and window
   task automatic mode(input logic sun, input logic win);
      @(posedge mclk);
      #1 sun_select = sun;
      space_window = win;
   endtask
   // Revolution mark, then time for the step to settle
   task automatic rev();
      @(posedge mclk);
      #1 rev_start = 1'b1;
      repeat (4) @(posedge mclk);
      #1 rev_start = 1'b0;
      repeat (12) @(posedge mclk);
   endtask
   // Starts one cycle after a tick, so no tick lands near an edge
   task automatic pulse(input int sel, input int w, output logic [15:0] t0);
      do @(posedge mclk); while (ph != 3'h7);
      @(posedge mclk);
      #1 t0 = sys_time;
      lvl(sel, 1'b1);
      repeat (8 * w + 2) @(posedge mclk);
      #1 lvl(sel, 1'b0);
      repeat (4) @(posedge mclk);
   endtask
   task automatic lvl(input int sel, input logic v);
      star_pulse = (sel == 0) ? v : star_pulse;
      sun_slit0 = (sel == 1) ? v : sun_slit0;
      sun_slit1 = (sel == 2) ? v : sun_slit1;
   endtask
endmodule
